// file: hw/vic_top.sv
/*
 * Vectored interrupt controller: request, mask and priority flags, fixed-order
 * resolution, vector hand-off to the CPU core, standby release, AXI4-Lite registers.
 * Assumes the CPU core handshakes with cpu_take and signals nmi return with cpu_nmi_return.
 */
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module vic_top #(
    parameter logic HAS_I2C_DEFAULT = 1'b1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // request sources
    input wire logic watchdog_request,
    input wire logic [6:0] pin_edge_request,
    input wire logic [7:0] port4_pins,
    input wire logic [14:0] internal_request,
    input wire logic break_instruction,
    // cpu core side
    input wire logic cpu_take,
    input wire logic cpu_nmi_return,
    output logic irq_pending,
    output logic ack_strobe,
    output logic [15:0] vector_address,
    output logic standby_release,
    output logic in_service_priority
);
    logic [23:0] req_reg, req_next;
    logic [23:0] mask_reg;
    logic [23:0] prio_reg;
    logic [2:0] ctrl_reg;
    logic nmi_pend_reg, nmi_busy_reg, brk_pend_reg, isp_reg;
    logic [7:0] port4_sync, port4_prev_reg;
    logic [6:0] pin_sync;
    logic [6:0] pin_prev_reg;
    logic ie, wdt_mode1, has_i2c;
    logic [23:0] src_events, eligible, sw_set, sw_clr, ack_clr, unused_bits;
    logic found;
    logic [4:0] winner;
    logic nmi_event, take_nmi, take_brk, take_mask;
    logic [1:0] kind;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    vic_sync #(.WIDTH(8)) u_sync_port4 (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_async(port4_pins),
        .pin_sync(port4_sync)
    );
    vic_sync #(.WIDTH(7)) u_sync_pins (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_async(pin_edge_request),
        .pin_sync(pin_sync)
    );

    // ************************************************************
    // control decode and source routing
    // ************************************************************
    assign ie = ctrl_reg[vic_pkg::CTRL_IE_BIT];
    assign wdt_mode1 = ctrl_reg[vic_pkg::CTRL_WDT_MODE1_BIT];
    assign has_i2c = ctrl_reg[vic_pkg::CTRL_HAS_I2C_BIT];
    // watchdog goes non-maskable only in mode 1
    assign nmi_event = watchdog_request & wdt_mode1;
    // pin edge inputs are edge pulses from the edge-select logic, caught on rise; port 4 pins are caught on fall
    assign src_events[0] = watchdog_request & ~wdt_mode1;
    assign src_events[7:1] = pin_sync & ~pin_prev_reg;
    assign src_events[8] = |(port4_prev_reg & ~port4_sync);
    assign src_events[23:9] = internal_request;
    assign unused_bits = has_i2c ? 24'h00_0000 : 24'h00_4000;

    // ************************************************************
    // eligibility and resolution
    // ************************************************************
    // low requests wait while a high one is in service
    assign eligible = req_reg & ~mask_reg & ~unused_bits
                    & (isp_reg ? 24'hff_ffff : ~prio_reg);
    vic_arbiter #(.N(vic_pkg::NUM_MASKABLE)) u_arb (
        .eligible(eligible),
        .prio_low(prio_reg),
        .found(found),
        .winner(winner)
    );
    // nmi first, then break, then maskable; nmi and maskable wait while nmi busy, break does not
    assign take_nmi = cpu_take & nmi_pend_reg & ~nmi_busy_reg;
    assign take_brk = cpu_take & ~take_nmi & brk_pend_reg;
    assign take_mask = cpu_take & ~take_nmi & ~take_brk & found & ie & ~nmi_busy_reg;
    assign kind = take_nmi ? 2'h1 : (take_brk ? 2'h2 : (take_mask ? 2'h3 : 2'h0));
    assign ack_clr = take_mask ? (24'h00_0001 << winner) : 24'h00_0000;

    // ************************************************************
    // axi4-lite decode
    // ************************************************************
    logic aw_held_reg, w_held_reg;
    logic [31:0] awaddr_reg, wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_go, wr_hit, rd_hit;
    logic [31:0] rd_word;
    assign wr_go = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    assign wr_hit = awaddr_reg == vic_pkg::REQ_LOW0_ADDR || awaddr_reg == vic_pkg::REQ_HIGH0_ADDR
                 || awaddr_reg == vic_pkg::REQ_LOW1_ADDR || awaddr_reg == vic_pkg::MASK_LOW0_ADDR
                 || awaddr_reg == vic_pkg::MASK_HIGH0_ADDR || awaddr_reg == vic_pkg::MASK_LOW1_ADDR
                 || awaddr_reg == vic_pkg::PRIO_LOW0_ADDR || awaddr_reg == vic_pkg::PRIO_HIGH0_ADDR
                 || awaddr_reg == vic_pkg::PRIO_LOW1_ADDR || awaddr_reg == vic_pkg::CTRL_ADDR;
    // byte writes of lane 0 only; the 16-bit pairs are two word writes
    function automatic logic [23:0] lane(input logic [31:0] a, input logic [31:0] b0,
                                         input logic [31:0] b1, input logic [31:0] b2,
                                         input logic [7:0] d);
        logic [23:0] r;
        r = 24'h00_0000;
        if (a == b0) begin
            r = {16'h0000, d};
        end else if (a == b1) begin
            r = {8'h00, d, 8'h00};
        end else if (a == b2) begin
            r = {d, 16'h0000};
        end
        return r;
    endfunction
    function automatic logic [23:0] hit(input logic [31:0] a, input logic [31:0] b0,
                                        input logic [31:0] b1, input logic [31:0] b2);
        logic [23:0] r;
        r = 24'h00_0000;
        if (a == b0) begin
            r = 24'h00_00ff;
        end else if (a == b1) begin
            r = 24'h00_ff00;
        end else if (a == b2) begin
            r = 24'hff_0000;
        end
        return r;
    endfunction
    logic wr_en;
    logic [23:0] req_sel, mask_sel, prio_sel, req_wd, mask_wd, prio_wd;
    assign wr_en = wr_go & wstrb_reg[0];
    assign req_sel = wr_en ? hit(awaddr_reg, vic_pkg::REQ_LOW0_ADDR, vic_pkg::REQ_HIGH0_ADDR,
                                 vic_pkg::REQ_LOW1_ADDR) : 24'h00_0000;
    assign mask_sel = wr_en ? hit(awaddr_reg, vic_pkg::MASK_LOW0_ADDR, vic_pkg::MASK_HIGH0_ADDR,
                                  vic_pkg::MASK_LOW1_ADDR) : 24'h00_0000;
    assign prio_sel = wr_en ? hit(awaddr_reg, vic_pkg::PRIO_LOW0_ADDR, vic_pkg::PRIO_HIGH0_ADDR,
                                  vic_pkg::PRIO_LOW1_ADDR) : 24'h00_0000;
    assign req_wd = lane(awaddr_reg, vic_pkg::REQ_LOW0_ADDR, vic_pkg::REQ_HIGH0_ADDR,
                         vic_pkg::REQ_LOW1_ADDR, wdata_reg[7:0]);
    assign mask_wd = lane(awaddr_reg, vic_pkg::MASK_LOW0_ADDR, vic_pkg::MASK_HIGH0_ADDR,
                          vic_pkg::MASK_LOW1_ADDR, wdata_reg[7:0]);
    assign prio_wd = lane(awaddr_reg, vic_pkg::PRIO_LOW0_ADDR, vic_pkg::PRIO_HIGH0_ADDR,
                          vic_pkg::PRIO_LOW1_ADDR, wdata_reg[7:0]);
    // watchdog flag is not writable in mode 1
    assign sw_set = req_sel & req_wd & {23'h7f_ffff, ~wdt_mode1};
    assign sw_clr = req_sel & ~req_wd & {23'h7f_ffff, ~wdt_mode1};
    // hardware set beats any clear in the same cycle
    assign req_next = ((req_reg & ~sw_clr & ~ack_clr) | sw_set | src_events)
                    & ~unused_bits;

    // read mux; watchdog request and mask bits read 0 in mode 1
    logic [23:0] req_view, mask_view;
    assign req_view = req_reg & {23'h7f_ffff, ~wdt_mode1};
    assign mask_view = mask_reg & {23'h7f_ffff, ~wdt_mode1};
    assign rd_hit = 1'b1;
    always_comb begin
        case (s_axi_araddr)
            vic_pkg::REQ_LOW0_ADDR: rd_word = {24'h00_0000, req_view[7:0]};
            vic_pkg::REQ_HIGH0_ADDR: rd_word = {24'h00_0000, req_view[15:8]};
            vic_pkg::REQ_LOW1_ADDR: rd_word = {24'h00_0000, req_view[23:16]};
            vic_pkg::MASK_LOW0_ADDR: rd_word = {24'h00_0000, mask_view[7:0]};
            vic_pkg::MASK_HIGH0_ADDR: rd_word = {24'h00_0000, mask_view[15:8]};
            vic_pkg::MASK_LOW1_ADDR: rd_word = {24'h00_0000, mask_view[23:16]};
            vic_pkg::PRIO_LOW0_ADDR: rd_word = {24'h00_0000, prio_reg[7:0]};
            vic_pkg::PRIO_HIGH0_ADDR: rd_word = {24'h00_0000, prio_reg[15:8]};
            vic_pkg::PRIO_LOW1_ADDR: rd_word = {24'h00_0000, prio_reg[23:16]};
            vic_pkg::CTRL_ADDR: rd_word = {29'h0000_0000, ctrl_reg};
            vic_pkg::STATUS_ADDR: rd_word = {27'h000_0000, isp_reg, nmi_busy_reg,
                                             nmi_pend_reg, brk_pend_reg, found};
            default: rd_word = 32'hffff_ffff;
        endcase
    end
    logic rd_ok;
    assign rd_ok = rd_word != 32'hffff_ffff;

    // ************************************************************
    // axi4-lite channel handshakes
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= vic_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? vic_pkg::RESP_OKAY : vic_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
            end
        end
    end

    // read answers one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= vic_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid & rd_hit;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_ok ? rd_word : 32'h0000_0000;
                s_axi_rresp <= rd_ok ? vic_pkg::RESP_OKAY : vic_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // flag registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_reg <= {3{vic_pkg::REQ_RESET}};
            mask_reg <= {3{vic_pkg::MASK_RESET}};
            prio_reg <= {3{vic_pkg::PRIO_RESET}};
            ctrl_reg <= {HAS_I2C_DEFAULT, 2'b00};
            pin_prev_reg <= 7'h00;
            port4_prev_reg <= 8'h00; // matches synchroniser reset, so release makes no false fall
        end else begin
            req_reg <= req_next;
            mask_reg <= (mask_reg & ~mask_sel) | (mask_wd & mask_sel);
            prio_reg <= (prio_reg & ~prio_sel) | (prio_wd & prio_sel);
            if (wr_en && awaddr_reg == vic_pkg::CTRL_ADDR) begin
                ctrl_reg <= wdata_reg[2:0];
            end else if (kind != 2'h0) begin
                ctrl_reg[vic_pkg::CTRL_IE_BIT] <= 1'b0; // acceptance disables nesting
            end
            pin_prev_reg <= pin_sync;
            port4_prev_reg <= port4_sync;
        end
    end

    // ************************************************************
    // non-maskable and break tracking; in-service priority
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_pend_reg <= 1'b0;
            nmi_busy_reg <= 1'b0;
            brk_pend_reg <= 1'b0;
            isp_reg <= 1'b1;
        end else begin
            // a new event holds pending; repeats collapse into one
            nmi_pend_reg <= nmi_event | (nmi_pend_reg & ~take_nmi);
            nmi_busy_reg <= take_nmi | (nmi_busy_reg & ~cpu_nmi_return);
            brk_pend_reg <= break_instruction | (brk_pend_reg & ~take_brk);
            if (take_nmi) begin
                isp_reg <= 1'b0;
            end else if (take_mask) begin
                isp_reg <= prio_reg[winner];
            end else if (cpu_nmi_return) begin
                isp_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // cpu-facing outputs, all registered
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_strobe <= 1'b0;
            vector_address <= 16'h0000;
            irq_pending <= 1'b0;
            standby_release <= 1'b0;
            in_service_priority <= 1'b1;
        end else begin
            ack_strobe <= kind != 2'h0;
            if (take_nmi) begin
                vector_address <= vic_pkg::NMI_VECTOR;
            end else if (take_brk) begin
                vector_address <= vic_pkg::BREAK_VECTOR;
            end else if (take_mask) begin
                // index n maps to 0004H + 2n: pins 0006H..0012H, key 0014H, last 0032H
                vector_address <= vic_pkg::MASKABLE_VECTOR_BASE
                                + {10'h000, winner, 1'b0};
            end
            irq_pending <= (nmi_pend_reg & ~nmi_busy_reg) | brk_pend_reg
                         | (found & ie & ~nmi_busy_reg);
            // standby release ignores enable; halt and stop both end on it
            standby_release <= nmi_pend_reg | (|(req_reg & ~mask_reg));
            in_service_priority <= isp_reg;
        end
    end
endmodule

// file: hw/vic_pkg.sv
/*
 * Constants, register map and vector table of the vectored interrupt controller.
 * Assumes a 32-bit AXI4-Lite register bus; each 8-bit register occupies one aligned word.
 */
// How it works
// - Non-maskable request ignores enable and priority, wins always, waits while one serviced.
// - Only the watchdog overflow is non-maskable, vectored at 0004H.
// - Non-maskable request raises standby release, ending halt mode.
// - Maskable request raises standby release, ending stop and halt modes.
// - Priority flag puts each maskable request in high or low group; high nests.
// - Equal-priority pending requests resolve by fixed order 0 highest to 23 lowest.
// - Eight external and sixteen internal maskable request inputs.
// - Break instruction is a software interrupt at 003EH, ignoring enable and priority.
// - Twenty-six sources in total: non-maskable, maskable and software.
// - Watchdog is non-maskable in watchdog mode 1, maskable order 0 in interval mode.
// - Pin edges vector 0006H to 0012H by two; internal ones 0016H to 0032H.
// - Falling edge on any port 4 bit raises key-return request, vector 0014H, order 8.
// - Without I2C, vector 0020H has no source; its flag bits stay unused.
// - Request flag sets by source or software, clears on acknowledge, reset, software.
// - Request flags reset to 00H; byte, bit and combined 16-bit access; code writes lane-0 bytes only, a 16-bit pair as two word writes.
// - Acknowledge clears the matching request flag before service starts.
// - Watchdog request flag accessible only in interval mode; software keeps it 0 otherwise.
// - Mask flag 0 enables, 1 blocks; masks reset to FFH; byte and 16-bit access; code writes lane-0 bytes only, a 16-bit pair as two word writes.
// - In watchdog mode 1 the watchdog mask flag reads undefined.
// - Priority registers reset to FFH with the documented bit layout.
// - Maskable request eligible when flag is 1 and mask is 0; taken if enable is 1.
// - Acknowledge copies priority flag into in-service priority; low waits while it is 0.
package vic_pkg;

    // ************************************************************
    // register offsets and byte addresses (addresses word aligned)
    // ************************************************************
    localparam logic [15:0] PRIO_LOW0_OFS = 16'hffe8;
    localparam logic [15:0] PRIO_HIGH0_OFS = 16'hffe9;
    localparam logic [15:0] PRIO_LOW1_OFS = 16'hffea;
    localparam logic [31:0] PRIO_LOW0_ADDR = 32'h0003_ffa0;
    localparam logic [31:0] PRIO_HIGH0_ADDR = 32'h0003_ffa4;
    localparam logic [31:0] PRIO_LOW1_ADDR = 32'h0003_ffa8;
    localparam logic [31:0] REQ_LOW0_ADDR = 32'h0000_0000;
    localparam logic [31:0] REQ_HIGH0_ADDR = 32'h0000_0004;
    localparam logic [31:0] REQ_LOW1_ADDR = 32'h0000_0008;
    localparam logic [31:0] MASK_LOW0_ADDR = 32'h0000_0010;
    localparam logic [31:0] MASK_HIGH0_ADDR = 32'h0000_0014;
    localparam logic [31:0] MASK_LOW1_ADDR = 32'h0000_0018;
    localparam logic [31:0] CTRL_ADDR = 32'h0000_0020;
    localparam logic [31:0] STATUS_ADDR = 32'h0000_0024;

    // ************************************************************
    // reset values and field positions
    // ************************************************************
    localparam logic [7:0] REQ_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'hff;
    localparam logic [7:0] PRIO_RESET = 8'hff;
    localparam int CTRL_IE_BIT = 0;
    localparam int CTRL_WDT_MODE1_BIT = 1;
    localparam int CTRL_HAS_I2C_BIT = 2;
    localparam int NUM_MASKABLE = 24;
    localparam int WDT_ORDER = 0;
    localparam int KEY_ORDER = 8;
    localparam int I2C_ORDER = 14;
    localparam int NUM_SOURCES = 26;

    // ************************************************************
    // vector table
    // ************************************************************
    localparam logic [15:0] NMI_VECTOR = 16'h0004;
    localparam logic [15:0] MASKABLE_VECTOR_BASE = 16'h0004;
    localparam logic [15:0] BREAK_VECTOR = 16'h003e;

    // ************************************************************
    // bus response codes
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        VIC_IDLE = 2'b00,
        VIC_ACK = 2'b01,
        VIC_NMI_BUSY = 2'b10
    } vic_state_t;

endpackage

// file: hw/vic_sync.sv
/*
 * Two-flop synchroniser for a bundle of asynchronous pins.
 * Assumes the pins change slowly relative to aclk; no glitch filter.
 */
`timescale 1ns/1ps
module vic_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pins and result
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_reg;

    // ************************************************************
    // two stages; first stage feeds only the second
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            pin_sync <= '0;
        end else begin
            meta_reg <= pin_async;
            pin_sync <= meta_reg;
        end
    end
endmodule

// file: hw/vic_arbiter.sv
/*
 * Fixed-order two-level priority picker for the maskable requests.
 * Assumes eligible already combines flag, mask and in-service priority.
 */
`timescale 1ns/1ps
module vic_arbiter #(
    parameter int N = 24
) (
    // requests
    input wire logic [N-1:0] eligible,
    input wire logic [N-1:0] prio_low,
    // winner
    output logic found,
    output logic [4:0] winner
);
    logic [N-1:0] high_set;
    logic [N-1:0] pick_set;

    // high group first, then low group
    assign high_set = eligible & ~prio_low;
    assign pick_set = (|high_set) ? high_set : eligible;
    assign found = |eligible;

    // ************************************************************
    // lowest index wins: scan downward so index 0 lands last
    // ************************************************************
    always_comb begin
        winner = 5'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (pick_set[i]) begin
                winner = 5'(i);
            end
        end
    end
endmodule

// file: tb/vic_top_properties.sv
/* port assertions of the interrupt controller.
   assumes binding into vic_top; one clock domain. */
`timescale 1ns/1ps
module vic_top_checker (
    input wire logic aclk, aresetn, cpu_take, irq_pending, ack_strobe, standby_release,
    input wire logic in_service_priority, s_axi_bvalid, s_axi_bready,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [15:0] vector_address
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // hand-off to the core: strobe, cause and vector
    ack_pulse_a: assert property (ack_strobe |=> !ack_strobe) else $error("ack too long");
    ack_cause_a: assert property (ack_strobe |-> $past(cpu_take)) else $error("ack untaken");
    take_ack_a: assert property (cpu_take && irq_pending |=> ack_strobe)
        else $error("take not answered");
    vec_hold_a: assert property (!ack_strobe |-> $stable(vector_address))
        else $error("vector moved");
    vec_range_a: assert property (ack_strobe |-> !vector_address[0] &&
        (vector_address inside {[16'h0004:16'h0032], 16'h003e})) else $error("bad vector");
    // a serviced hardware request must have woken the core first
    wake_first_a: assert property (ack_strobe && vector_address != 16'h003e |->
        $past(standby_release) || $past(standby_release, 2)) else $error("no wake");
    reset_out_a: assert property ($rose(aresetn) |-> in_service_priority && !ack_strobe
        && !irq_pending) else $error("bad reset state");
    // bus answers stand until taken
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        ##0 (s_axi_rready || $stable(s_axi_rdata)) [*2]) else $error("read answer late");
    cover property (ack_strobe && vector_address == 16'h0004);
    cover property (ack_strobe && vector_address == 16'h003e);
    cover property (ack_strobe && vector_address == 16'h0014);
endmodule
bind vic_top vic_top_checker vic_top_checker_i (.*);

// file: tb/vic_core_model.sv
/* cpu core stand-in: takes pending requests, returns from nmi service.
   assumes ack_strobe follows an accepted take by one cycle. */
`timescale 1ns/1ps
module vic_core_model (
    input wire logic aclk, aresetn, irq_pending, ack_strobe,
    input wire logic [15:0] vector_address,
    output logic cpu_take, cpu_nmi_return
);
    logic [3:0] busy_cnt;
    // one take per ack; slow nmi service so a repeat request must wait
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_take <= 1'b0; cpu_nmi_return <= 1'b0; busy_cnt <= 4'h0;
        end else begin
            cpu_take <= irq_pending & ~cpu_take & ~ack_strobe;
            cpu_nmi_return <= (busy_cnt == 4'h1);
            if (ack_strobe && vector_address == 16'h0004) busy_cnt <= 4'h8;
            else if (busy_cnt != 4'h0) busy_cnt <= busy_cnt - 4'h1;
        end
    end
endmodule

// file: tb/vic_top_bench.sv
/* self-checking bench of the interrupt controller.
   assumes the core model answers takes; registers over axi4-lite. */
`timescale 1ns/1ps
module vic_top_bench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic watchdog_request, break_instruction, cpu_take, cpu_nmi_return, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_pending, ack_strobe;
    logic standby_release, in_service_priority;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [6:0] pin_edge_request;
    logic [7:0] port4_pins;
    logic [14:0] internal_request;
    logic [15:0] vector_address;
    int n_errors = 0;
    int check_count = 0;
    typedef struct {logic [31:0] addr; logic [7:0] data; logic [1:0] resp;} vic_row_t;
    vic_row_t rows [6] = '{'{32'h0, 8'h00, 2'h0}, '{32'h8, 8'h00, 2'h0}, '{32'h10, 8'hff, 2'h0},
        '{32'h18, 8'hff, 2'h0}, '{32'h3ffa4, 8'hff, 2'h0}, '{32'h30, 8'h00, 2'h2}};
    vic_top vic_top_i (.*);
    vic_core_model vic_core_model_i (.aclk, .aresetn, .irq_pending, .ack_strobe,
        .vector_address, .cpu_take, .cpu_nmi_return);
    initial begin aclk = 0; forever #25 aclk = ~aclk; end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin n_errors++; $display("MISMATCH %s exp %h got %h", what, exp, got); end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input vic_row_t r);
        @(posedge aclk);
        s_axi_araddr <= r.addr; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", {24'h0, r.data}, {24'h0, s_axi_rdata[7:0]});
        chk("rresp", {30'h0, r.resp}, {30'h0, s_axi_rresp});
    endtask
    // wait for the next hand-off; the watchdog cuts a hang
    task automatic ackw(input logic [15:0] v);
        do @(posedge aclk); while (ack_strobe !== 1'b1);
        chk("vector", {16'h0, v}, {16'h0, vector_address});
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin repeat (5000) @(posedge aclk); n_errors++; summarize; end
    initial begin
        aresetn = 0; {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = '0; s_axi_wdata = '0; s_axi_wstrb = '0; s_axi_araddr = '0;
        {watchdog_request, break_instruction} = '0; internal_request = '0;
        pin_edge_request = '0; port4_pins = 8'hff;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) rd(rows[i]);
        // pin and peripheral pending together, both at the low level
        wr(32'h10, 0); wr(32'h14, 0); wr(32'h18, 0);
        pin_edge_request <= 7'h04; internal_request <= 15'h0001;
        @(posedge aclk); internal_request <= '0;
        repeat (4) @(posedge aclk); pin_edge_request <= '0;
        wr(32'h20, 32'h5); ackw(16'h000a);
        wr(32'h20, 32'h5); ackw(16'h0016);
        port4_pins <= 8'hf7; repeat (4) @(posedge aclk);
        wr(32'h20, 32'h5); ackw(16'h0014);
        port4_pins <= 8'hff; break_instruction <= 1'b1; @(posedge aclk);
        break_instruction <= 1'b0; ackw(16'h003e);
        // repeat overflow in nmi service waits
        wr(32'h20, 32'h6); watchdog_request <= 1'b1; @(posedge aclk);
        watchdog_request <= 1'b0; ackw(16'h0004);
        watchdog_request <= 1'b1; @(posedge aclk); watchdog_request <= 1'b0; repeat (2) @(posedge aclk);
        chk("pending", 0, {31'h0, irq_pending}); ackw(16'h0004);
        wr(32'h20, 32'h5); wr(32'h18, 32'h1); internal_request <= 15'h0080; @(posedge aclk);
        internal_request <= '0; repeat (5) @(posedge aclk);
        chk("pending", 0, {31'h0, irq_pending}); rd('{32'h8, 8'h01, 2'h0});
        wr(32'h8, 0); rd('{32'h8, 8'h00, 2'h0});
        summarize;
    end
endmodule
